// ===== sim/lsc_exposure_readout_tb_top.sv
// Purpose: Self-checking bench for the exposure and readout control.
// Assumes: 50 MHz clock; grabber model drives the trigger pin.
// Notes: Sensor data held constant per scenario so binned sums are known.
`timescale 1ns/1ps
`default_nettype none
module lsc_exposure_readout_tb_top;
  import lsc_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic trig, ser_off, bin_n, clk15_n, integ, xfer, shift, strobe, lv, busy, user;
  logic [23:0] sensor, video, gain, offs, exp_video;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  int ihi = 0;
  int shifts = 0;
  // ============================================================
  // Block and far side
  lsc_exposure_readout DUT (.ref_clk_i(clk), .reset_i(rst), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .line_trigger_input_i(trig), .serial_off_i(ser_off), .bin_sel_n_i(bin_n),
    .clk_sel_n_i(clk15_n), .sensor_data_i(sensor), .integrate_o(integ),
    .transfer_o(xfer), .sensor_shift_o(shift), .video_o(video), .pix_strobe_o(strobe),
    .line_valid_output_o(lv), .trig_busy_o(busy), .trim_user_o(user), .gain_o(gain),
    .offset_o(offs));
  lsc_grabber_model grab (.ref_clk_i(clk), .line_trigger_o(trig), .video_i(video),
    .pix_strobe_i(strobe), .line_valid_i(lv), .transfer_i(xfer), .exp_video_i(exp_video));
  // ============================================================
  // Clock, cycle count, integration run length, sensor shift count
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  always @(posedge clk) ihi <= integ ? ihi + 1 : 0;
  always @(posedge clk) shifts <= shift ? shifts + 1 : shifts;
  // ============================================================
  // Common tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, seen);
      err_total++;
    end
  endtask
  // APB transfer; no fixed answer time is assumed
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk("apb_ready", 32'h0, 32'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(what, q & m, x);
    chk(what, {31'h0, e}, {31'h0, xe});
  endtask
  task automatic wait_xfer(output int t);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (xfer !== 1'b1 && n < 20000);
    if (n >= 20000) chk("xfer_wait", 32'h0, 32'h1);
    t = cyc;
  endtask
  // Three internal line starts: period, exposure run, one full line
  task automatic int_lines(input int p, input int ns, input int lmin, input int lmax,
                           output int w);
    int t0, t1, l0;
    wait_xfer(t0);
    wait_xfer(t0);
    grab.vbad = 0;
    wait_xfer(t1);
    w = ihi;
    l0 = grab.lines;
    chk("period", t1 - t0, p * US_CYC);
    while (grab.lines == l0 && t1 + 20000 > cyc) @(posedge clk);
    chk("strobes", grab.strobes_last, ns);
    chk("lv_len", grab.lv_last >= lmin && grab.lv_last <= lmax, 32'h1);
    chk("video", grab.vbad, 32'h0);
  endtask
  // ============================================================
  // Scenarios
  task automatic t_regs;
    rdc("ctrl_rst", A_CTRL, 32'hFFFFFFFF, 32'h0, 1'b0);
    rdc("scan_rst", A_SCAN, 32'hFFFFFFFF, 32'h7E5E, 1'b0);
    rdc("shut_rst", A_SHUT, 32'hFFFFFFFF, 32'h1, 1'b0);
    rdc("stat_rst", A_STAT, 32'h38, 32'h0, 1'b0);
    rdc("unmapped", 8'h1C, 32'hFFFFFFFF, 32'h0, 1'b1);
    rdc("misaligned", 8'h02, 32'hFFFFFFFF, 32'h0, 1'b1);
  endtask
  task automatic t_int_scan;
    int w;
    wr(A_SCAN, 32'h64);
    wr(A_CTRL, 32'h0);
    int_lines(151, 2048, 3400, 3430, w);
    chk("scan_open", integ, 1'b1);
  endtask
  task automatic t_int_shut;
    int w;
    sensor <= 24'h903010;
    exp_video <= 24'hFF6020;
    wr(A_SCAN, 32'hA0);
    wr(A_SHUT, 32'h5);
    wr(A_CTRL, 32'hE);
    int_lines(160, 1024, 6800, 6860, w);
    chk("shut_width", w >= 248 && w <= 252, 32'h1);
  endtask
  task automatic t_ext_shut;
    int s0;
    sensor <= 24'h102030;
    exp_video <= 24'h102030;
    grab.hold(1'b1, 5);
    wr(A_CTRL, 32'h3);
    grab.hold(1'b1, 20);
    grab.xfers = 0;
    grab.vbad = 0;
    s0 = shifts;
    @(posedge clk);
    chk("ext_idle", integ, 1'b0);
    grab.hold(1'b0, 400);
    @(posedge clk);
    chk("ext_integ", integ, 1'b1);
    chk("busy_on", busy, 1'b1);
    grab.hold(1'b1, 600);
    @(posedge clk);
    chk("ext_closed", integ, 1'b0);
    chk("ext_lines", grab.xfers, 32'h1);
    chk("ext_strobes", grab.strobes_last, 32'h800);
    chk("ext_shifts", shifts - s0, 32'h800);
  endtask
  task automatic t_ext_scan;
    grab.hold(1'b0, 20);
    wr(A_CTRL, 32'h1);
    grab.xfers = 0;
    grab.hold(1'b1, 10);
    grab.hold(1'b0, 450);
    grab.hold(1'b1, 10);
    grab.hold(1'b0, 300);
    grab.hold(1'b1, 10);
    grab.hold(1'b0, 500);
    @(posedge clk);
    chk("scan_lines", grab.xfers, 32'h2);
    chk("scan_video", grab.vbad, 32'h0);
  endtask
  task automatic t_pins;
    wr(A_CTRL, 32'h0);
    repeat (8) @(posedge clk);
    chk("busy_off", busy, 1'b0);
    ser_off <= 1'b1;
    bin_n <= 1'b0;
    repeat (8) @(posedge clk);
    rdc("pin_bin", A_STAT, 32'h18, 32'h8, 1'b0);
    bin_n <= 1'b1;
    clk15_n <= 1'b0;
    repeat (8) @(posedge clk);
    rdc("pin_clk", A_STAT, 32'h18, 32'h10, 1'b0);
    ser_off <= 1'b0;
    repeat (8) @(posedge clk);
    rdc("pin_off", A_STAT, 32'h18, 32'h0, 1'b0);
  endtask
  task automatic t_sets;
    wr(A_GAIN, 32'h112233);
    wr(A_OFFS, 32'h445566);
    wr(A_CTRL, 32'h8);
    wr(A_CFG, 32'h12);
    wr(A_CFG, 32'h40);
    repeat (2) @(posedge clk);
    rdc("fact_ctrl", A_CTRL, 32'hF, 32'h0, 1'b0);
    chk("fact_gain", gain, 32'h0);
    chk("fact_offs", offs, 32'h0);
    chk("fact_user", user, 1'b0);
    wr(A_CFG, 32'h22);
    repeat (2) @(posedge clk);
    rdc("user_ctrl", A_CTRL, 32'hF, 32'h8, 1'b0);
    chk("user_gain", gain, 32'h112233);
    chk("user_offs", offs, 32'h445566);
    chk("user_on", user, 1'b1);
  endtask
  // ============================================================
  // Verdict, watchdog and main sequence
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Longest path is about 75k cycles; this allows some slack
  initial begin
    #2_000_000;
    err_total++;
    give_verdict;
  end
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    {ser_off, bin_n, clk15_n} = 3'h3;
    sensor = 24'h102030;
    exp_video = 24'h102030;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_int_scan;
    t_int_shut;
    t_ext_shut;
    t_ext_scan;
    t_pins;
    t_sets;
    give_verdict;
  end
endmodule
`default_nettype wire

// ===== sim/lsc_grabber_model.sv
// Purpose: Frame grabber model: drives the line trigger, captures video lines.
// Assumes: Video, strobe and line valid belong to the reference clock domain.
// Notes: Trigger steps on its own 160 ns link clock, which stops between calls.
`timescale 1ns/1ps
`default_nettype none
module lsc_grabber_model (
  // Clock
  input wire logic ref_clk_i,
  // Trigger towards the block
  output logic line_trigger_o,
  // Video from the block
  input wire logic [23:0] video_i,
  input wire logic pix_strobe_i,
  input wire logic line_valid_i,
  input wire logic transfer_i,
  input wire logic [23:0] exp_video_i
);
  logic link_clk = 1'b0;
  int strobes = 0;
  int strobes_last = 0;
  int lv_len = 0;
  int lv_last = 0;
  int lo_cnt = 0;
  int lines = 0;
  int xfers = 0;
  int vbad = 0;
  initial line_trigger_o = 1'b0;
  // ============================================================
  // Trigger drive
  // Caller keeps highs over 4 pixel periods; t_ext_scan puts one rise under 2120 pixel periods after the last
  task automatic hold(input logic lvl, input int n);
    #7;
    line_trigger_o = lvl;
    repeat (n) begin
      link_clk = 1'b1;
      #80;
      link_clk = 1'b0;
      #80;
    end
  endtask
  // ============================================================
  // Capture; a line is closed a few cycles after line valid drops
  // so that a strobe trailing the fall is still counted with its line
  always @(posedge ref_clk_i) begin
    if (transfer_i) xfers <= xfers + 1;
    if (pix_strobe_i) strobes <= strobes + 1;
    if (pix_strobe_i && video_i !== exp_video_i) vbad <= vbad + 1;
    lo_cnt <= line_valid_i ? 0 : lo_cnt + 1;
    if (line_valid_i) lv_len <= lv_len + 1;
    if (!line_valid_i && lo_cnt == 4 && lv_len != 0) begin
      strobes_last <= strobes;
      lv_last <= lv_len;
      lines <= lines + 1;
      strobes <= 0;
      lv_len <= 0;
    end
  end
endmodule
`default_nettype wire

// ===== verilog/lsc_exposure_readout.sv
// Purpose: Line trigger, exposure and pixel readout control with APB config.
// Assumes: ref_clk_i 50 MHz; trigger and select pins are asynchronous.
// Notes: Pixel clock is an enable pulse; sensor data is same-domain logic.
`timescale 1ns/1ps
`default_nettype none
module lsc_exposure_readout (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Pins from the frame grabber side
  input wire logic line_trigger_input_i,
  input wire logic serial_off_i,
  input wire logic bin_sel_n_i,
  input wire logic clk_sel_n_i,
  // Sensor side
  input wire logic [23:0] sensor_data_i,
  output logic integrate_o,
  output logic transfer_o,
  output logic sensor_shift_o,
  // Video out
  output logic [23:0] video_o,
  output logic pix_strobe_o,
  output logic line_valid_output_o,
  output logic trig_busy_o,
  // Colour trim
  output logic trim_user_o,
  output logic [23:0] gain_o,
  output logic [23:0] offset_o
);
  import lsc_pkg::*;

  // ============================================================
  // Pin synchronisers
  logic [3:0] pins_s;
  logic trig_s, serial_off_s, bin_n_s, clk_n_s;
  lsc_sync2 #(.WIDTH(4)) u_sync (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .async_i({clk_sel_n_i, bin_sel_n_i, serial_off_i, line_trigger_input_i}),
    .sync_o(pins_s)
  );
  assign {clk_n_s, bin_n_s, serial_off_s, trig_s} = pins_s;

  // ============================================================
  // Configuration registers and user sets
  logic [3:0] ctrl_q, ctrl_d;
  logic [15:0] scan_q, scan_d, shut_q, shut_d;
  logic [23:0] gain_q, gain_d, offs_q, offs_d;
  logic user_q, user_d;
  logic [31:0] prdata_d;
  logic pready_d, pslverr_d;
  logic [3:0] set_ctrl [NUM_SETS];
  logic [15:0] set_scan [NUM_SETS];
  logic [15:0] set_shut [NUM_SETS];
  logic [23:0] set_gain [NUM_SETS];
  logic [23:0] set_offs [NUM_SETS];
  logic wr_en, rd_setup, mapped, store_en;
  logic [1:0] set_idx;
  logic ext_mode, shut_mode, bin_act, clk15_act;
  // Timing-side state read back by status
  logic integ_q, line_valid_q, busy_q;
  logic [15:0] line_cnt_q;

  assign set_idx = pwdata_i[1:0];
  assign mapped = (paddr_i <= A_STAT) && (paddr_i[1:0] == 2'b00);
  assign rd_setup = psel_i && !penable_i;
  // Writes land only at the access edge that sees pready
  assign wr_en = psel_i && penable_i && pready_o && pwrite_i && mapped;
  assign store_en = wr_en && (paddr_i == A_CFG) && pwdata_i[CFG_STORE];
  assign ext_mode = ctrl_q[CB_EXT];
  assign shut_mode = ctrl_q[CB_SHUT];
  // Serial port off hands binning and rate to the pins
  assign bin_act = serial_off_s ? !bin_n_s : ctrl_q[CB_BIN];
  assign clk15_act = serial_off_s ? !clk_n_s : ctrl_q[CB_CLK15];

  // Register writes, set loads and the registered APB answer
  always_comb begin
    ctrl_d = ctrl_q;
    scan_d = scan_q;
    shut_d = shut_q;
    gain_d = gain_q;
    offs_d = offs_q;
    user_d = user_q;
    pready_d = rd_setup;
    pslverr_d = rd_setup && !mapped;
    prdata_d = '0;
    // Register writes stand in for the 9600 baud 8N1 serial commands
    if (wr_en) begin
      case (paddr_i)
        A_CTRL: ctrl_d = pwdata_i[3:0];
        A_SCAN: begin
          // Out-of-range periods are clamped rather than refused
          if (pwdata_i[15:0] < SCAN_MIN_US) scan_d = SCAN_MIN_US;
          else if (pwdata_i[15:0] > SCAN_MAX_US) scan_d = SCAN_MAX_US;
          else scan_d = pwdata_i[15:0];
        end
        A_SHUT: shut_d = pwdata_i[15:0];
        A_GAIN: gain_d = pwdata_i[23:0];
        A_OFFS: offs_d = pwdata_i[23:0];
        A_CFG: begin
          if (pwdata_i[CFG_FACT]) begin
            // Factory values are constants, so no write can alter them
            ctrl_d = FACT_CTRL;
            scan_d = FACT_SCAN_US;
            shut_d = SHUT_MIN_US;
            user_d = 1'b0;
          end else if (pwdata_i[CFG_LOAD]) begin
            ctrl_d = set_ctrl[set_idx];
            scan_d = set_scan[set_idx];
            shut_d = set_shut[set_idx];
            gain_d = set_gain[set_idx];
            offs_d = set_offs[set_idx];
            user_d = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (rd_setup) begin
      case (paddr_i)
        A_CTRL: prdata_d = {28'h0000000, ctrl_q};
        A_SCAN: prdata_d = {16'h0000, scan_q};
        A_SHUT: prdata_d = {16'h0000, shut_q};
        A_GAIN: prdata_d = {8'h00, gain_q};
        A_OFFS: prdata_d = {8'h00, offs_q};
        A_STAT: prdata_d = {line_cnt_q, 10'h000, user_q, clk15_act, bin_act, busy_q,
                            integ_q, line_valid_q};
        default: prdata_d = '0;
      endcase
    end
  end

  // Reset brings up the factory set
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ctrl_q <= FACT_CTRL;
      scan_q <= FACT_SCAN_US;
      shut_q <= SHUT_MIN_US;
      gain_q <= '0;
      offs_q <= '0;
      user_q <= 1'b0;
      prdata_o <= '0;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      gain_o <= '0;
      offset_o <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      scan_q <= scan_d;
      shut_q <= shut_d;
      gain_q <= gain_d;
      offs_q <= offs_d;
      user_q <= user_d;
      prdata_o <= prdata_d;
      pready_o <= pready_d;
      pslverr_o <= pslverr_d;
      gain_o <= user_d ? gain_d : '0;
      offset_o <= user_d ? offs_d : '0;
    end
  end

  // User set storage; plain memory, contents undefined until stored
  always_ff @(posedge ref_clk_i) begin
    if (store_en) begin
      set_ctrl[set_idx] <= ctrl_q;
      set_scan[set_idx] <= scan_q;
      set_shut[set_idx] <= shut_q;
      set_gain[set_idx] <= gain_q;
      set_offs[set_idx] <= offs_q;
    end
  end

  // ============================================================
  // Line timing, exposure and readout
  lsc_rd_e rd_q, rd_d;
  logic [5:0] us_div_q, us_div_d;
  logic [6:0] pix_acc_q, pix_acc_d, acc_sum;
  logic [15:0] line_us_q, line_us_d, busy_cnt_q, busy_cnt_d, shut_eff, shut_lim;
  logic [15:0] line_cnt_d;
  logic [11:0] gap_q, gap_d;
  logic [10:0] pix_idx_q, pix_idx_d;
  logic [23:0] pair_q, pair_d, video_d;
  logic [8:0] chan_sum;
  logic trig_prev_q, us_tick, pix_en, trig_rise, trig_fall, gap_ok, line_start;
  logic integ_d, xfer_d, shift_d, strobe_d, line_valid_d, busy_d;

  assign trig_rise = trig_s && !trig_prev_q;
  assign trig_fall = !trig_s && trig_prev_q;
  // Microsecond tick runs off the system clock only, whatever the pixel rate
  assign us_tick = (us_div_q == US_CYC_M1);
  assign acc_sum = pix_acc_q + (clk15_act ? PIX_INC_15 : PIX_INC_30);
  assign pix_en = (acc_sum >= PIX_ACC_MOD);
  // Gap in pixel periods is what caps the line rate at either pixel clock
  assign gap_ok = (gap_q > GAP_LIMIT_PIX);
  assign shut_lim = scan_q - SHUT_MARGIN_US;
  assign shut_eff = (shut_q < SHUT_MIN_US) ? SHUT_MIN_US :
                    (shut_q > shut_lim) ? shut_lim : shut_q;

  always_comb begin
    us_div_d = us_tick ? 6'h00 : us_div_q + 6'h01;
    pix_acc_d = pix_en ? acc_sum - PIX_ACC_MOD : acc_sum;
    line_us_d = line_us_q;
    busy_cnt_d = busy_cnt_q;
    gap_d = (pix_en && !gap_ok) ? gap_q + 12'h001 : gap_q;
    rd_d = rd_q;
    pix_idx_d = pix_idx_q;
    pair_d = pair_q;
    video_d = video_o;
    chan_sum = '0;
    integ_d = integ_q;
    line_start = 1'b0;
    shift_d = 1'b0;
    strobe_d = 1'b0;
    if (ext_mode) begin
      // Programmed period and exposure play no part here
      line_us_d = '0;
      if (trig_rise || trig_fall) busy_cnt_d = BUSY_HOLD_US;
      else if (us_tick && busy_cnt_q != '0) busy_cnt_d = busy_cnt_q - 16'h0001;
      if (trig_rise && gap_ok) line_start = 1'b1;
      if (!shut_mode) integ_d = 1'b1;
      else if (trig_fall) integ_d = 1'b1;
      else if (trig_rise) integ_d = 1'b0;
    end else begin
      busy_cnt_d = '0;
      if (us_tick) begin
        if (line_us_q >= scan_q - 16'h0001) begin
          line_us_d = '0;
          line_start = gap_ok;
        end else begin
          line_us_d = line_us_q + 16'h0001;
        end
      end
      // Shutter opens the last shut_eff microseconds of each period
      if (shut_mode) integ_d = (line_us_d >= scan_q - shut_eff);
      else integ_d = 1'b1;
    end
    if (line_start) gap_d = '0;
    xfer_d = line_start;
    // Readout of one line; a new transfer only starts after the gap
    case (rd_q)
      RD_IDLE: begin
        pix_idx_d = '0;
        if (line_start) rd_d = RD_SHIFT;
      end
      RD_SHIFT: begin
        if (pix_en) begin
          shift_d = 1'b1;
          pix_idx_d = pix_idx_q + 11'h001;
          if (!bin_act) begin
            video_d = sensor_data_i;
            strobe_d = 1'b1;
          end else if (!pix_idx_q[0]) begin
            pair_d = sensor_data_i;
          end else begin
            // Pair sum saturates at full scale per colour
            for (int c = 0; c < 3; c++) begin
              chan_sum = {1'b0, pair_q[c*8 +: 8]} + {1'b0, sensor_data_i[c*8 +: 8]};
              video_d[c*8 +: 8] = chan_sum[8] ? 8'hFF : chan_sum[7:0];
            end
            strobe_d = 1'b1;
          end
          if (pix_idx_q == LAST_PIX) rd_d = RD_IDLE;
        end
      end
      default: rd_d = RD_IDLE;
    endcase
    line_valid_d = (rd_d == RD_SHIFT);
    busy_d = ext_mode && (busy_cnt_d != '0);
    line_cnt_d = line_start ? line_cnt_q + 16'h0001 : line_cnt_q;
  end

  // Timing registers; integration is open at reset as in internal scan
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      us_div_q <= '0;
      pix_acc_q <= '0;
      line_us_q <= '0;
      busy_cnt_q <= '0;
      gap_q <= '0;
      rd_q <= RD_IDLE;
      pix_idx_q <= '0;
      pair_q <= '0;
      trig_prev_q <= 1'b0;
      integ_q <= 1'b1;
      line_valid_q <= 1'b0;
      busy_q <= 1'b0;
      line_cnt_q <= '0;
      transfer_o <= 1'b0;
      sensor_shift_o <= 1'b0;
      pix_strobe_o <= 1'b0;
      video_o <= '0;
    end else begin
      us_div_q <= us_div_d;
      pix_acc_q <= pix_acc_d;
      line_us_q <= line_us_d;
      busy_cnt_q <= busy_cnt_d;
      gap_q <= gap_d;
      rd_q <= rd_d;
      pix_idx_q <= pix_idx_d;
      pair_q <= pair_d;
      trig_prev_q <= trig_s;
      integ_q <= integ_d;
      line_valid_q <= line_valid_d;
      busy_q <= busy_d;
      line_cnt_q <= line_cnt_d;
      transfer_o <= xfer_d;
      sensor_shift_o <= shift_d;
      pix_strobe_o <= strobe_d;
      video_o <= video_d;
    end
  end

  assign integrate_o = integ_q;
  assign line_valid_output_o = line_valid_q;
  assign trig_busy_o = busy_q;
  assign trim_user_o = user_q;

  // ============================================================
  // Checks
  a_gap_guard: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    transfer_o |-> $past(gap_q) > GAP_LIMIT_PIX) else $error("transfer too soon");
  a_ext_shut_open: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (ext_mode && shut_mode && trig_fall) |=> integrate_o) else $error("no open on fall");
  a_ext_shut_close: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (ext_mode && shut_mode && trig_rise && !trig_fall) |=> !integrate_o)
    else $error("no close on rise");
  a_scan_exposed: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (!shut_mode && $past(!shut_mode)) |-> integrate_o) else $error("scan gap in exposure");
  a_bin_pairs: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (pix_strobe_o && $past(bin_act)) |-> $past(pix_idx_q[0])) else $error("bin strobe rate");
  a_valid_span: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    transfer_o == $rose(line_valid_output_o)) else $error("line valid start");
  a_scan_range: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    scan_q >= SCAN_MIN_US && scan_q <= SCAN_MAX_US && shut_eff <= scan_q - SHUT_MARGIN_US)
    else $error("period out of range");
  a_int_wrap: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (!ext_mode && us_tick && line_us_q >= scan_q - 16'h0001) |=> line_us_q == '0)
    else $error("period wrap missed");
  a_busy_ext: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    trig_busy_o |-> $past(ext_mode)) else $error("busy outside external");
  a_factory_trim: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !trim_user_o |-> (gain_o == '0 && offset_o == '0)) else $error("trim under factory");
endmodule
`default_nettype wire

// ===== verilog/lsc_pkg.sv
// Purpose: Shared constants for the line scan exposure and readout control.
// Assumes: 50 MHz system clock; 32-bit APB register port.
// Notes: Times are kept in their own unit; cycle counts derive from them.
`default_nettype none
package lsc_pkg;
  // ============================================================
  // Clocking
  localparam int REF_CLK_HZ = 50_000_000;
  localparam int US_CYC = REF_CLK_HZ / 1_000_000;
  localparam logic [5:0] US_CYC_M1 = 6'(US_CYC - 1);
  // Pixel periods in ps; enable rate is a phase accumulator step per ref cycle
  localparam int PIX_PER_30_PS = 33300;
  localparam int PIX_PER_15_PS = 66600;
  localparam logic [6:0] PIX_INC_30 = 7'(1_000_000 / PIX_PER_30_PS);
  localparam logic [6:0] PIX_INC_15 = 7'(1_000_000 / PIX_PER_15_PS);
  localparam logic [6:0] PIX_ACC_MOD = 7'(REF_CLK_HZ / 1_000_000);
  // ============================================================
  // Line geometry and timing limits
  localparam logic [10:0] LAST_PIX = 11'h7FF;
  localparam logic [11:0] GAP_LIMIT_PIX = 12'h848;
  localparam logic [15:0] SCAN_MIN_US = 16'h0097;
  localparam logic [15:0] SCAN_MAX_US = 16'h7E5E;
  localparam logic [15:0] SHUT_MARGIN_US = 16'h0096;
  localparam logic [15:0] SHUT_MIN_US = 16'h0001;
  localparam logic [15:0] FACT_SCAN_US = 16'h7E5E;
  localparam logic [15:0] BUSY_HOLD_US = 16'hFFFF;
  localparam int NUM_SETS = 4;
  // ============================================================
  // Register map (byte addresses)
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_SCAN = 8'h04;
  localparam logic [7:0] A_SHUT = 8'h08;
  localparam logic [7:0] A_GAIN = 8'h0C;
  localparam logic [7:0] A_OFFS = 8'h10;
  localparam logic [7:0] A_CFG = 8'h14;
  localparam logic [7:0] A_STAT = 8'h18;
  // CTRL fields
  localparam int CB_EXT = 0;
  localparam int CB_SHUT = 1;
  localparam int CB_BIN = 2;
  localparam int CB_CLK15 = 3;
  localparam logic [3:0] FACT_CTRL = 4'h0;
  // CFG fields: set index in bits 1:0, one-shot actions above
  localparam int CFG_STORE = 4;
  localparam int CFG_LOAD = 5;
  localparam int CFG_FACT = 6;
  typedef enum logic {RD_IDLE, RD_SHIFT} lsc_rd_e;
endpackage
`default_nettype wire

// ===== verilog/lsc_sync2.sv
// Purpose: Two-flop synchroniser for a group of unrelated level inputs.
// Assumes: Each bit is an independent level; no word coherence needed.
// Notes: First stage is read by the second stage only.
`timescale 1ns/1ps
`default_nettype none
module lsc_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Levels
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;
  // ============================================================
  // Two stages, cleared by reset
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule
`default_nettype wire
